// file: toy_clock_pkg.sv
// Constants for the time-of-year clock: register slots, field positions,
// reset values and cycle counts.
// Assumes a 250 MHz system clock; no other file is needed.
`default_nettype none

package toy_clock_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int SECOND_US = 1000000;
    localparam int BUSY_LEAD_US = 244;
    localparam int UPDATE_US = 1948;
    localparam int SECOND_CYC = SECOND_US * CLK_MHZ;
    localparam int BUSY_LEAD_CYC = BUSY_LEAD_US * CLK_MHZ;
    localparam int UPDATE_CYC = UPDATE_US * CLK_MHZ;
    localparam int PHASE_W = 28;

    // ------------------------------------------------------------------
    // Register slots (longword index) and byte placement
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_SEC = 6'h00;
    localparam logic [5:0] IDX_MIN = 6'h02;
    localparam logic [5:0] IDX_HOUR = 6'h04;
    localparam logic [5:0] IDX_DOW = 6'h06;
    localparam logic [5:0] IDX_DAY = 6'h07;
    localparam logic [5:0] IDX_MON = 6'h08;
    localparam logic [5:0] IDX_YEAR = 6'h09;
    localparam logic [5:0] IDX_DIV = 6'h0A;
    localparam logic [5:0] IDX_MODE = 6'h0B;
    localparam logic [5:0] IDX_FLAGS = 6'h0C;
    localparam logic [5:0] IDX_VALID = 6'h0D;
    localparam int BYTE_LSB = 2;
    localparam int BYTE_MSB = 9;

    // ------------------------------------------------------------------
    // Field positions within the 8-bit register
    // ------------------------------------------------------------------
    localparam int BUSY_BIT = 7;
    localparam int DIV_HI = 6;
    localparam int DIV_LO = 4;
    localparam int RATE_HI = 3;
    localparam int RATE_LO = 0;
    localparam int INHIBIT_BIT = 7;
    localparam int BINARY_BIT = 2;
    localparam int HOUR24_BIT = 1;
    localparam int DST_BIT = 0;
    localparam int VALID_BIT = 7;
    localparam int PM_BIT = 7;

    // ------------------------------------------------------------------
    // Values
    // ------------------------------------------------------------------
    localparam logic [2:0] DIV_RUN = 3'h2;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [3:0] RATE_RESET = 4'h0;
    localparam logic [7:0] MODE_RESET = 8'h80;
    localparam logic [7:0] SEC_RESET = 8'h00;
    localparam logic [7:0] HOUR_RESET = 8'h00;
    localparam logic [7:0] DOW_RESET = 8'h01;
    localparam logic [7:0] DAY_RESET = 8'h01;
    localparam logic [7:0] MON_RESET = 8'h01;
    localparam logic [7:0] YEAR_RESET = 8'h00;
    localparam logic [7:0] MAX_MS = 8'h3B;
    localparam logic [7:0] MAX_HOUR = 8'h17;
    localparam logic [7:0] NOON = 8'h0C;
    localparam logic [7:0] SUNDAY = 8'h01;
    localparam logic [7:0] SATURDAY = 8'h07;
    localparam logic [7:0] APRIL = 8'h04;
    localparam logic [7:0] FEBRUARY = 8'h02;
    localparam logic [7:0] OCTOBER = 8'h0A;
    localparam logic [7:0] DECEMBER = 8'h0C;
    localparam logic [7:0] MAX_YEAR = 8'h63;
    localparam logic [7:0] LAST_WEEK_FIRST_DAY = 8'h19;
    localparam logic [7:0] DST_HOUR = 8'h01;
    localparam logic [7:0] SPRING_HOUR = 8'h03;

endpackage

`default_nettype wire

// file: scratch_port_if.sv
// Port between the clock core and its byte store.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none

interface scratch_port_if;
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// file: scratch_mem.sv
// Byte store for the alarm and general-purpose storage slots.
// Assumes one access per cycle; read data appear one cycle after the address.
`timescale 1ns/1ns
`default_nettype none

module scratch_mem #(
    parameter int DEPTH = 64
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    scratch_port_if.mem port
);
    logic [7:0] store [DEPTH];
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = store[port.addr];
    end

    // Contents are kept across reset, as a battery-backed store would be
    always_ff @(posedge sys_clk) begin
        if (port.we) begin
            store[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign port.rdata = rdata_q;
endmodule

`default_nettype wire

// file: toy_clock.sv
// Time-of-year clock: calendar counters, control registers and byte store
// behind a 64-slot longword register window.
// Assumes the host issues single-cycle read or write strobes, word or
// longword wide, synchronous to sys_clk.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Update-in-progress reads one from 244 us before update until it ends.
// - Divider field is read/write; only value 010 lets the clock run.
// - Rate field is read/write storage; software keeps it zero.
// - Inhibit bit clear: advance each second; set: abort and block updates.
// - Format bit one means binary, zero means two decimal digits per byte.
// - Hour bit one is 24-hour; zero is 12-hour with bit 7 as PM.
// - Daylight bit: April skip 01:59:59 to 03:00, October repeat hour once.
// - Validity flag clears when battery is low while system power is off.
// - Reading the validity register sets the flag afterwards; writes ignored.
// - Bits 8:2 of the validity register read zero.
// - Seconds, minutes, hours, day, month, year and weekday 1 to 7 counters.
// - Each update lasts 1948 us while time contents are unstable.
// - Registers sit in bits 9:2 of a longword; other bits ignored.
// - 64 register slots: time, alarm, control and 50 storage bytes.
module toy_clock #(
    parameter int SECOND_CYC = toy_clock_pkg::SECOND_CYC,
    parameter int BUSY_LEAD_CYC = toy_clock_pkg::BUSY_LEAD_CYC,
    parameter int UPDATE_CYC = toy_clock_pkg::UPDATE_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic battery_low,
    input wire logic system_power_off,
    output logic update_in_progress
);
    localparam logic [toy_clock_pkg::PHASE_W-1:0] LAST_PHASE =
        toy_clock_pkg::PHASE_W'(SECOND_CYC - 1);
    localparam logic [toy_clock_pkg::PHASE_W-1:0] BUSY_START =
        toy_clock_pkg::PHASE_W'(SECOND_CYC - BUSY_LEAD_CYC - UPDATE_CYC);

    // ------------------------------------------------------------------
    // Format conversion
    // ------------------------------------------------------------------
    function automatic logic [7:0] to_fmt(input logic [7:0] v, input logic bin);
        logic [7:0] tens;
        tens = v / 8'h0A;
        to_fmt = bin ? v : {tens[3:0], 4'(v - tens * 8'h0A)};
    endfunction

    function automatic logic [7:0] from_fmt(input logic [7:0] v, input logic bin);
        from_fmt = bin ? v : 8'(v[7:4] * 8'h0A + {4'h0, v[3:0]});
    endfunction

    function automatic logic [7:0] days_in(input logic [7:0] mon, input logic [7:0] yr);
        case (mon)
            8'h04, 8'h06, 8'h09, 8'h0B: days_in = 8'h1E;
            toy_clock_pkg::FEBRUARY: days_in = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
            default: days_in = 8'h1F;
        endcase
    endfunction

    function automatic logic is_store(input logic [5:0] idx);
        is_store = (idx > toy_clock_pkg::IDX_VALID) || (idx == 6'h01) || (idx == 6'h03) || (idx == 6'h05);
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [toy_clock_pkg::PHASE_W-1:0] phase_q, phase_d;
    logic [7:0] sec_q, sec_d, min_q, min_d, hour_q, hour_d;
    logic [7:0] dow_q, dow_d, day_q, day_d, mon_q, mon_d, year_q, year_d;
    logic [2:0] div_q, div_d;
    logic [3:0] rate_q, rate_d;
    logic [7:0] mode_q, mode_d;
    logic valid_q, valid_d;
    logic fall_done_q, fall_done_d;
    logic [7:0] rbyte_q, rbyte_d;
    logic rvalid_q, rvalid_d;
    logic from_store_q, from_store_d;

    logic [5:0] idx;
    logic [7:0] wbyte;
    logic bin;
    logic running;
    logic tick;
    logic in_last_week;
    logic at_dst_point;
    logic [7:0] h12;
    logic [7:0] hour_rd;
    logic [7:0] hour_wr;

    scratch_port_if sp ();

    scratch_mem #(
        .DEPTH(64)
    ) u_store (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .port(sp.mem)
    );

    // Only bits 9:2 carry the register; the rest is ignored
    assign idx = reg_addr[7:2];
    assign wbyte = reg_wdata[toy_clock_pkg::BYTE_MSB:toy_clock_pkg::BYTE_LSB];
    assign bin = mode_q[toy_clock_pkg::BINARY_BIT];
    assign running = !mode_q[toy_clock_pkg::INHIBIT_BIT] && (div_q == toy_clock_pkg::DIV_RUN);
    assign tick = running && (phase_q == LAST_PHASE);
    // Flag spans the lead time plus the unstable update tail of each second
    assign update_in_progress = running && (phase_q >= BUSY_START);
    assign in_last_week = (dow_q == toy_clock_pkg::SUNDAY) && (day_q >= toy_clock_pkg::LAST_WEEK_FIRST_DAY);
    assign at_dst_point = mode_q[toy_clock_pkg::DST_BIT] && in_last_week && (hour_q == toy_clock_pkg::DST_HOUR)
        && (min_q == toy_clock_pkg::MAX_MS) && (sec_q == toy_clock_pkg::MAX_MS);

    assign sp.addr = idx;
    assign sp.we = reg_wr && is_store(idx);
    assign sp.wdata = wbyte;

    // ------------------------------------------------------------------
    // Hour encoding
    // ------------------------------------------------------------------
    always_comb begin
        hour_rd = to_fmt(hour_q, bin);
        h12 = from_fmt({1'b0, wbyte[6:0]}, bin);
        hour_wr = from_fmt(wbyte, bin);
        if (!mode_q[toy_clock_pkg::HOUR24_BIT]) begin
            if (hour_q == 8'h00) begin
                hour_rd = to_fmt(toy_clock_pkg::NOON, bin);
            end else if (hour_q > toy_clock_pkg::NOON) begin
                hour_rd = to_fmt(8'(hour_q - toy_clock_pkg::NOON), bin);
            end
            // Noon and later carry the afternoon marker
            if (hour_q >= toy_clock_pkg::NOON) begin
                hour_rd[toy_clock_pkg::PM_BIT] = 1'b1;
            end
            if (h12 == toy_clock_pkg::NOON) begin
                hour_wr = wbyte[toy_clock_pkg::PM_BIT] ? toy_clock_pkg::NOON : 8'h00;
            end else begin
                hour_wr = wbyte[toy_clock_pkg::PM_BIT] ? 8'(h12 + toy_clock_pkg::NOON) : h12;
            end
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        phase_d = phase_q;
        sec_d = sec_q;
        min_d = min_q;
        hour_d = hour_q;
        dow_d = dow_q;
        day_d = day_q;
        mon_d = mon_q;
        year_d = year_q;
        div_d = div_q;
        rate_d = rate_q;
        mode_d = mode_q;
        valid_d = valid_q;
        fall_done_d = fall_done_q;

        // Inhibit parks the phase at zero, so a half-done update is dropped
        if (!running || tick) begin
            phase_d = '0;
        end else begin
            phase_d = phase_q + 1'b1;
        end

        if (tick) begin
            if (at_dst_point && (mon_q == toy_clock_pkg::APRIL)) begin
                hour_d = toy_clock_pkg::SPRING_HOUR;
                min_d = 8'h00;
                sec_d = 8'h00;
            end else if (at_dst_point && (mon_q == toy_clock_pkg::OCTOBER) && !fall_done_q) begin
                // Repeat the hour only once; the flag is dropped on the next day
                min_d = 8'h00;
                sec_d = 8'h00;
                fall_done_d = 1'b1;
            end else if (sec_q != toy_clock_pkg::MAX_MS) begin
                sec_d = sec_q + 8'h01;
            end else begin
                sec_d = 8'h00;
                if (min_q != toy_clock_pkg::MAX_MS) begin
                    min_d = min_q + 8'h01;
                end else begin
                    min_d = 8'h00;
                    if (hour_q != toy_clock_pkg::MAX_HOUR) begin
                        hour_d = hour_q + 8'h01;
                    end else begin
                        hour_d = 8'h00;
                        fall_done_d = 1'b0;
                        dow_d = (dow_q == toy_clock_pkg::SATURDAY) ? toy_clock_pkg::SUNDAY : 8'(dow_q + 8'h01);
                        if (day_q < days_in(mon_q, year_q)) begin
                            day_d = day_q + 8'h01;
                        end else begin
                            day_d = 8'h01;
                            if (mon_q != toy_clock_pkg::DECEMBER) begin
                                mon_d = mon_q + 8'h01;
                            end else begin
                                mon_d = 8'h01;
                                year_d = (year_q == toy_clock_pkg::MAX_YEAR) ? 8'h00 : 8'(year_q + 8'h01);
                            end
                        end
                    end
                end
            end
        end

        // Host writes land after the update so a fresh value is not lost
        if (reg_wr) begin
            case (idx)
                toy_clock_pkg::IDX_SEC: sec_d = from_fmt(wbyte, bin);
                toy_clock_pkg::IDX_MIN: min_d = from_fmt(wbyte, bin);
                toy_clock_pkg::IDX_HOUR: hour_d = hour_wr;
                toy_clock_pkg::IDX_DOW: dow_d = from_fmt(wbyte, bin);
                toy_clock_pkg::IDX_DAY: day_d = from_fmt(wbyte, bin);
                toy_clock_pkg::IDX_MON: mon_d = from_fmt(wbyte, bin);
                toy_clock_pkg::IDX_YEAR: year_d = from_fmt(wbyte, bin);
                toy_clock_pkg::IDX_DIV: begin
                    div_d = wbyte[toy_clock_pkg::DIV_HI:toy_clock_pkg::DIV_LO];
                    rate_d = wbyte[toy_clock_pkg::RATE_HI:toy_clock_pkg::RATE_LO];
                end
                toy_clock_pkg::IDX_MODE: mode_d = wbyte;
                default: begin
                end
            endcase
        end

        // Power-loss clear outranks the read-to-set
        if (reg_rd && (idx == toy_clock_pkg::IDX_VALID)) begin
            valid_d = 1'b1;
        end
        if (battery_low && system_power_off) begin
            valid_d = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rvalid_d = reg_rd;
        from_store_d = is_store(idx);
        case (idx)
            toy_clock_pkg::IDX_SEC: rbyte_d = to_fmt(sec_q, bin);
            toy_clock_pkg::IDX_MIN: rbyte_d = to_fmt(min_q, bin);
            toy_clock_pkg::IDX_HOUR: rbyte_d = hour_rd;
            toy_clock_pkg::IDX_DOW: rbyte_d = to_fmt(dow_q, bin);
            toy_clock_pkg::IDX_DAY: rbyte_d = to_fmt(day_q, bin);
            toy_clock_pkg::IDX_MON: rbyte_d = to_fmt(mon_q, bin);
            toy_clock_pkg::IDX_YEAR: rbyte_d = to_fmt(year_q, bin);
            toy_clock_pkg::IDX_DIV: rbyte_d = {update_in_progress, div_q, rate_q};
            toy_clock_pkg::IDX_MODE: rbyte_d = mode_q;
            toy_clock_pkg::IDX_VALID: rbyte_d = {valid_q, 7'h00};
            default: rbyte_d = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            phase_q <= '0;
            sec_q <= toy_clock_pkg::SEC_RESET;
            min_q <= toy_clock_pkg::SEC_RESET;
            hour_q <= toy_clock_pkg::HOUR_RESET;
            dow_q <= toy_clock_pkg::DOW_RESET;
            day_q <= toy_clock_pkg::DAY_RESET;
            mon_q <= toy_clock_pkg::MON_RESET;
            year_q <= toy_clock_pkg::YEAR_RESET;
            div_q <= toy_clock_pkg::DIV_RESET;
            rate_q <= toy_clock_pkg::RATE_RESET;
            mode_q <= toy_clock_pkg::MODE_RESET;
            valid_q <= 1'b0;
            fall_done_q <= 1'b0;
            rbyte_q <= 8'h00;
            rvalid_q <= 1'b0;
            from_store_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            sec_q <= sec_d;
            min_q <= min_d;
            hour_q <= hour_d;
            dow_q <= dow_d;
            day_q <= day_d;
            mon_q <= mon_d;
            year_q <= year_d;
            div_q <= div_d;
            rate_q <= rate_d;
            mode_q <= mode_d;
            valid_q <= valid_d;
            fall_done_q <= fall_done_d;
            rbyte_q <= rbyte_d;
            rvalid_q <= rvalid_d;
            from_store_q <= from_store_d;
        end
    end

    assign reg_rvalid = rvalid_q;
    assign reg_rdata = {22'h000000, from_store_q ? sp.rdata : rbyte_q, 2'h0};
endmodule

`default_nettype wire

// file: toy_clock_monitor.sv
// Checker for the time-of-year clock, watching the top module's ports.
// Assumes toy_clock_pkg is compiled first; bound onto toy_clock below.
`timescale 1ns/1ns
`default_nettype none

module toy_clock_monitor #(
    parameter int SECOND_CYC = 200,
    parameter int BUSY_LEAD_CYC = 10,
    parameter int UPDATE_CYC = 40
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic battery_low,
    input wire logic system_power_off,
    input wire logic update_in_progress
);
    int hi_q, hi_d, lo_q, lo_d;
    wire logic rd_v = reg_rd && reg_addr[7:2] == toy_clock_pkg::IDX_VALID;
    wire logic clr = battery_low && system_power_off;
    wire logic wr_inhibit = reg_wr && reg_addr[7:2] == toy_clock_pkg::IDX_MODE && reg_wdata[9];

    // ----------------------------------------------------------------
    // Flag run lengths
    // ----------------------------------------------------------------
    // Counters rather than long repetitions keep the checks cheap
    always_comb begin
        hi_d = update_in_progress ? hi_q + 1 : 0;
        lo_d = update_in_progress ? 0 : lo_q + 1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            hi_q <= 0;
            lo_q <= 0;
        end else begin
            hi_q <= hi_d;
            lo_q <= lo_d;
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    AST_READ_ANSWER: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    AST_NO_STRAY_ANSWER: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without a read");
    AST_BYTE_LANES: assert property (reg_rvalid |-> reg_rdata[31:10] == 22'h0 && reg_rdata[1:0] == 2'h0)
        else $error("read data outside the register byte");
    AST_VALID_PAD_ZERO: assert property (rd_v |=> reg_rdata[8:2] == 7'h00)
        else $error("validity pad bits not zero");
    AST_VALID_SET_BY_READ: assert property (rd_v && !clr ##1 rd_v && !clr |=> reg_rdata[9])
        else $error("validity flag not set by read");
    AST_VALID_CLEARED: assert property (clr ##1 rd_v && !clr |=> !reg_rdata[9])
        else $error("validity flag not cleared");
    AST_BUSY_MAX_WIDTH: assert property (update_in_progress |-> hi_q < BUSY_LEAD_CYC + UPDATE_CYC)
        else $error("update flag high too long");
    AST_BUSY_GAP: assert property ($rose(update_in_progress) |-> lo_q >= SECOND_CYC - BUSY_LEAD_CYC - UPDATE_CYC)
        else $error("update flag rose too early");
    AST_RESET_QUIET: assert property ($fell(sys_rst) |-> !reg_rvalid && !update_in_progress)
        else $error("outputs busy after reset");
    AST_FLAGS_SLOT_ZERO: assert property (reg_rd && reg_addr[7:2] == toy_clock_pkg::IDX_FLAGS |=> reg_rdata == 32'h0)
        else $error("interrupt flag slot not zero");
    AST_INHIBIT_STOPS: assert property (wr_inhibit |=> !update_in_progress)
        else $error("update flag not dropped by inhibit");

    COV_VALID_TWICE: cover property (rd_v ##1 rd_v);
    COV_UPDATE_DONE: cover property ($fell(update_in_progress));
    COV_CLEAR_READ: cover property (clr ##1 rd_v);
endmodule

bind toy_clock toy_clock_monitor #(
    .SECOND_CYC(SECOND_CYC),
    .BUSY_LEAD_CYC(BUSY_LEAD_CYC),
    .UPDATE_CYC(UPDATE_CYC)
) u_monitor (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .battery_low(battery_low),
    .system_power_off(system_power_off),
    .update_in_progress(update_in_progress)
);

`default_nettype wire

// file: toy_clock_tb.sv
// Self-checking bench for the time-of-year clock.
// Assumes the package, design and checker files are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module toy_clock_tb;
    localparam int SEC = 200;
    localparam int LEAD = 10;
    localparam int UPD = 40;
    localparam logic [5:0] TS [7] = '{toy_clock_pkg::IDX_SEC, toy_clock_pkg::IDX_MIN, toy_clock_pkg::IDX_HOUR,
        toy_clock_pkg::IDX_DOW, toy_clock_pkg::IDX_DAY, toy_clock_pkg::IDX_MON, toy_clock_pkg::IDX_YEAR};
    // Last entry revisits the October point on the same day: no second repeat
    localparam logic [7:0] DST_MODE [4] = '{8'h07, 8'h07, 8'h06, 8'h07};
    localparam logic [7:0] DMON [4] = '{8'h04, 8'h0A, 8'h04, 8'h0A};
    localparam logic [7:0] DDAY [4] = '{8'h1D, 8'h1C, 8'h1D, 8'h1C};
    localparam logic [7:0] DHR [4] = '{8'h03, 8'h01, 8'h02, 8'h02};
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_rvalid;
    logic battery_low = 1'b0;
    logic system_power_off = 1'b0;
    logic update_in_progress;
    logic [31:0] exp_q [$];
    logic [31:0] e;
    logic [7:0] b;
    int n_errors = 0;
    int check_count = 0;
    int seed = 42;
    int cycles = 0;
    int n;

    // Short second so a full update fits in a few hundred cycles
    toy_clock #(.SECOND_CYC(SEC), .BUSY_LEAD_CYC(LEAD), .UPDATE_CYC(UPD)) uut (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_rd(reg_rd),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .battery_low(battery_low),
        .system_power_off(system_power_off),
        .update_in_progress(update_in_progress)
    );

    always #2 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // Bus tasks
    // ----------------------------------------------------------------
    // Strobes stay up between calls, so reads and writes run back to back
    task automatic wr(input logic [5:0] s, input logic [7:0] d);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= {s, 2'h0};
        reg_wdata <= ($random(seed) & 32'hFFFFFC03) | {22'h0, d, 2'h0};
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [5:0] s, input logic [7:0] d);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= {s, 2'h0};
        exp_q.push_back({22'h0, d, 2'h0});
        @(posedge sys_clk);
    endtask

    task automatic idle(input int k);
        reg_rd <= 1'b0;
        reg_wr <= 1'b0;
        repeat (k) @(posedge sys_clk);
    endtask

    task automatic wait_uip(input logic lv);
        n = 0;
        while (update_in_progress !== lv && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK("update flag", lv, update_in_progress)
    endtask

    task automatic set_time(input logic [7:0] m, input logic [55:0] t);
        wr(toy_clock_pkg::IDX_MODE, m | 8'h80);
        for (int i = 0; i < 7; i++) wr(TS[i], t[55 - 8 * i -: 8]);
        wr(toy_clock_pkg::IDX_DIV, 8'h20);
        wr(toy_clock_pkg::IDX_MODE, m & 8'h7F);
        idle(1);
    endtask

    task automatic check_time(input logic [55:0] t);
        for (int i = 0; i < 7; i++) rd(TS[i], t[55 - 8 * i -: 8]);
        idle(1);
    endtask

    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Read answer scoreboard and timeout
    // ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 12000) begin
            n_errors++;
            final_report();
        end
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("wrong value rdata expected none seen %0h", reg_rdata);
            end else begin
                e = exp_q.pop_front();
                `CHK("rdata", e, reg_rdata)
            end
        end
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        check_time(56'h00_00_12_01_01_01_00);
        rd(toy_clock_pkg::IDX_DIV, 8'h00);
        rd(toy_clock_pkg::IDX_MODE, 8'h80);
        rd(toy_clock_pkg::IDX_FLAGS, 8'h00);
        rd(toy_clock_pkg::IDX_VALID, 8'h00);
        rd(toy_clock_pkg::IDX_VALID, 8'h80);
        wr(toy_clock_pkg::IDX_VALID, 8'h00);
        wr(toy_clock_pkg::IDX_FLAGS, 8'hFF);
        rd(toy_clock_pkg::IDX_VALID, 8'h80);
        rd(toy_clock_pkg::IDX_FLAGS, 8'h00);
        battery_low <= 1'b1;
        system_power_off <= 1'b1;
        idle(2);
        system_power_off <= 1'b0;
        rd(toy_clock_pkg::IDX_VALID, 8'h00);
        rd(toy_clock_pkg::IDX_VALID, 8'h80);
        rd(toy_clock_pkg::IDX_VALID, 8'h80);
        battery_low <= 1'b0;
        b = 8'($random(seed));
        wr(6'h0E, b);
        wr(6'h3F, ~b);
        wr(toy_clock_pkg::IDX_DIV, {1'b1, 3'h5, b[3:0]});
        rd(6'h0E, b);
        rd(6'h3F, ~b);
        rd(toy_clock_pkg::IDX_DIV, {1'b0, 3'h5, b[3:0]});
        idle(1);
        // Year end in binary 24-hour: every counter carries at once
        set_time(8'h06, 56'h3B_3B_17_07_1F_0C_63);
        wait_uip(1'b1);
        `CHK("flag lead", 1'b1, n >= SEC - LEAD - UPD - 4 && n <= SEC - LEAD - UPD)
        wait_uip(1'b0);
        `CHK("flag width", LEAD + UPD, n)
        check_time(56'h00_00_00_01_01_01_00);
        // Decimal digits, 12-hour: 11:59:59 PM rolls to 12 AM next day
        set_time(8'h00, 56'h59_59_91_01_01_01_00);
        wait_uip(1'b1);
        rd(toy_clock_pkg::IDX_DIV, 8'hA0);
        idle(1);
        wait_uip(1'b0);
        check_time(56'h00_00_12_02_02_01_00);
        wait_uip(1'b1);
        wr(toy_clock_pkg::IDX_MODE, 8'h80);
        idle(2);
        `CHK("aborted flag", 1'b0, update_in_progress)
        idle(SEC + 10);
        rd(toy_clock_pkg::IDX_SEC, 8'h00);
        for (int i = 0; i < 4; i++) begin
            set_time(DST_MODE[i], {8'h3B, 8'h3B, 8'h01, 8'h01, DDAY[i], DMON[i], 8'h00});
            wait_uip(1'b1);
            wait_uip(1'b0);
            rd(toy_clock_pkg::IDX_HOUR, DHR[i]);
            rd(toy_clock_pkg::IDX_MIN, 8'h00);
            idle(1);
        end
        // Wrong divider must hold the clock still
        set_time(8'h06, 56'h0);
        wr(toy_clock_pkg::IDX_DIV, 8'h30);
        idle(SEC + 20);
        `CHK("stopped flag", 1'b0, update_in_progress)
        rd(toy_clock_pkg::IDX_SEC, 8'h00);
        idle(4);
        final_report();
    end
endmodule

`default_nettype wire
